// ### t8pwm_pkg.sv
// Constants, types and carriers for the 8-bit PWM timer block.
// Assumes a 32-bit AHB-Lite register bus, word aligned.
package t8pwm_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CMPA = 8'h04;
  localparam logic [7:0] ADDR_CMPB = 8'h08;
  localparam logic [7:0] ADDR_COUNT = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  // Counter extremes
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hFF;
  // Status bit positions, status and control register widths
  localparam int ST_OVF = 0;
  localparam int ST_MATCH_A = 1;
  localparam int ST_MATCH_B = 2;
  localparam int ST_W = 3;
  localparam int CTRL_W = 15;
  // Prescaler width and tap positions
  localparam int PRESC_W = 10;
  localparam logic [PRESC_W-1:0] TAP_8 = 10'h007;
  localparam logic [PRESC_W-1:0] TAP_32 = 10'h01F;
  localparam logic [PRESC_W-1:0] TAP_64 = 10'h03F;
  localparam logic [PRESC_W-1:0] TAP_128 = 10'h07F;
  localparam logic [PRESC_W-1:0] TAP_256 = 10'h0FF;
  localparam logic [PRESC_W-1:0] TAP_1024 = 10'h3FF;
  // Reset values
  localparam logic [7:0] CMP_RST = 8'h00;
  localparam logic [ST_W-1:0] ST_RST = 3'h0;
  localparam logic [PRESC_W-1:0] PRESC_RST = 10'h000;

  typedef enum logic [2:0] {
    WAVE_NORMAL = 3'h0,
    WAVE_PC_FIXED = 3'h1,
    WAVE_CTC = 3'h2,
    WAVE_FAST_FIXED = 3'h3,
    WAVE_RSV4 = 3'h4,
    WAVE_PC_VAR = 3'h5,
    WAVE_RSV6 = 3'h6,
    WAVE_FAST_VAR = 3'h7
  } t8pwm_wave_e;

  typedef enum logic [1:0] {
    COM_OFF = 2'h0,
    COM_TOGGLE = 2'h1,
    COM_NONINV = 2'h2,
    COM_INV = 2'h3
  } t8pwm_com_e;

  typedef enum logic [2:0] {
    CLK_STOP = 3'h0,
    CLK_DIV1 = 3'h1,
    CLK_DIV8 = 3'h2,
    CLK_DIV32 = 3'h3,
    CLK_DIV64 = 3'h4,
    CLK_DIV128 = 3'h5,
    CLK_DIV256 = 3'h6,
    CLK_DIV1024 = 3'h7
  } t8pwm_clk_e;

  typedef enum logic {
    DIR_UP = 1'b0,
    DIR_DOWN = 1'b1
  } t8pwm_dir_e;

  // Control register, bit 0 upward from the bottom field
  typedef struct packed {
    logic pin_b_data;
    logic pin_a_data;
    logic pin_b_dir;
    logic pin_a_dir;
    logic async_sel;
    t8pwm_clk_e clk_sel;
    t8pwm_com_e chan_b_output_mode;
    t8pwm_com_e chan_a_output_mode;
    t8pwm_wave_e waveform_mode_sel;
  } t8pwm_ctrl_s;

  localparam t8pwm_ctrl_s CTRL_RST = 15'h0000;
endpackage

// ### t8pwm_top.sv
// 8-bit timer with fast and phase correct PWM, two compare channels,
// prescaler and AHB-Lite register slave.
// Assumes a single AHB-Lite master; osc_tick is synchronous to hclk.
//
// The implementer's own choices: the register addresses and the AHB-Lite register port.

module t8pwm_top (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Asynchronous timer source as enable
  input wire logic osc_tick,
  // Compare output pins
  output logic chan_a_pin_out,
  output logic chan_a_pin_oe,
  output logic chan_b_pin_out,
  output logic chan_b_pin_oe,
  // Observation
  output logic [7:0] counter_value,
  output logic overflow_flag,
  output logic chan_a_match_flag
);

  // Next output state of one compare channel
  function automatic logic oc_next(
    input t8pwm_pkg::t8pwm_wave_e wm,
    input t8pwm_pkg::t8pwm_com_e com,
    input logic oc,
    input logic match,
    input logic up,
    input logic wrap,
    input logic turn,
    input logic hold_top
  );
    logic r;
    logic lvl_up;
    r = oc;
    lvl_up = (com == t8pwm_pkg::COM_INV);
    unique case (wm)
      t8pwm_pkg::WAVE_FAST_FIXED, t8pwm_pkg::WAVE_FAST_VAR: begin
        if (com == t8pwm_pkg::COM_TOGGLE) begin
          if (match) r = ~oc;
        end else if (com != t8pwm_pkg::COM_OFF) begin
          if (match) r = lvl_up;
          if (wrap) r = ~lvl_up;
        end
      end
      t8pwm_pkg::WAVE_PC_FIXED, t8pwm_pkg::WAVE_PC_VAR: begin
        if (com == t8pwm_pkg::COM_NONINV || com == t8pwm_pkg::COM_INV) begin
          if (match) r = up ? lvl_up : ~lvl_up;
          if (turn) r = hold_top ? ~lvl_up : lvl_up;
        end
      end
      default: begin
        if (match) begin
          unique case (com)
            t8pwm_pkg::COM_OFF: r = oc;
            t8pwm_pkg::COM_TOGGLE: r = ~oc;
            t8pwm_pkg::COM_NONINV: r = 1'b0;
            t8pwm_pkg::COM_INV: r = 1'b1;
          endcase
        end
      end
    endcase
    return r;
  endfunction

  t8pwm_pkg::t8pwm_ctrl_s ctrl, next_ctrl;
  logic [7:0] cnt, next_cnt;
  t8pwm_pkg::t8pwm_dir_e dir, next_dir;
  logic [7:0] ocra, next_ocra, ocrb, next_ocrb;
  logic [7:0] bufa, next_bufa, bufb, next_bufb;
  logic oca, next_oca, ocb, next_ocb;
  logic [t8pwm_pkg::ST_W-1:0] flags, next_flags;
  logic [t8pwm_pkg::PRESC_W-1:0] presc, next_presc;
  logic wr_pend, next_wr_pend;
  logic [7:0] wr_addr, next_wr_addr;
  logic [31:0] next_hrdata;

  // Decoded mode and tick
  logic is_fast, is_pc, is_pwm, var_top;
  logic src_en, fire, tick;
  logic [7:0] top, new_top;
  logic at_top, wrap, turn, load;
  logic up_eff, match_a, match_b;
  logic ovf_set;

  always_comb begin
    is_fast = (ctrl.waveform_mode_sel == t8pwm_pkg::WAVE_FAST_FIXED) ||
              (ctrl.waveform_mode_sel == t8pwm_pkg::WAVE_FAST_VAR);
    is_pc = (ctrl.waveform_mode_sel == t8pwm_pkg::WAVE_PC_FIXED) ||
            (ctrl.waveform_mode_sel == t8pwm_pkg::WAVE_PC_VAR);
    is_pwm = is_fast || is_pc;
    var_top = (ctrl.waveform_mode_sel == t8pwm_pkg::WAVE_FAST_VAR) ||
              (ctrl.waveform_mode_sel == t8pwm_pkg::WAVE_PC_VAR);
    top = var_top ? ocra : t8pwm_pkg::CNT_MAX;
    new_top = var_top ? bufa : t8pwm_pkg::CNT_MAX;
    src_en = ctrl.async_sel ? osc_tick : 1'b1;
    unique case (ctrl.clk_sel)
      t8pwm_pkg::CLK_STOP: fire = 1'b0;
      t8pwm_pkg::CLK_DIV1: fire = 1'b1;
      t8pwm_pkg::CLK_DIV8: fire = presc[2:0] == t8pwm_pkg::TAP_8[2:0];
      t8pwm_pkg::CLK_DIV32: fire = presc[4:0] == t8pwm_pkg::TAP_32[4:0];
      t8pwm_pkg::CLK_DIV64: fire = presc[5:0] == t8pwm_pkg::TAP_64[5:0];
      t8pwm_pkg::CLK_DIV128: fire = presc[6:0] == t8pwm_pkg::TAP_128[6:0];
      t8pwm_pkg::CLK_DIV256: fire = presc[7:0] == t8pwm_pkg::TAP_256[7:0];
      t8pwm_pkg::CLK_DIV1024: fire = presc == t8pwm_pkg::TAP_1024;
    endcase
    tick = src_en && fire;
    next_presc = src_en ? t8pwm_pkg::PRESC_W'(presc + 1'b1) : presc;
    at_top = (cnt == top);
    wrap = tick && is_fast && at_top;
    turn = tick && is_pc && at_top && (dir == t8pwm_pkg::DIR_UP);
    load = is_pwm && (wrap || turn);
    up_eff = (dir == t8pwm_pkg::DIR_UP) || (cnt == t8pwm_pkg::CNT_BOTTOM);
    match_a = tick && (cnt == ocra);
    match_b = tick && (cnt == ocrb);
    ovf_set = is_pwm ? (wrap || (tick && is_pc &&
              cnt == t8pwm_pkg::CNT_BOTTOM))
              : (tick && cnt == t8pwm_pkg::CNT_MAX);
  end

  // Counter and direction
  always_comb begin
    next_cnt = cnt;
    next_dir = dir;
    if (tick) begin
      if (is_fast) begin
        next_cnt = at_top ? t8pwm_pkg::CNT_BOTTOM : 8'(cnt + 8'h01);
      end else if (is_pc) begin
        if (dir == t8pwm_pkg::DIR_UP) begin
          if (at_top) begin
            next_dir = t8pwm_pkg::DIR_DOWN;
            next_cnt = 8'(cnt - 8'h01);
          end else begin
            next_cnt = 8'(cnt + 8'h01);
          end
        end else if (cnt == t8pwm_pkg::CNT_BOTTOM) begin
          next_dir = t8pwm_pkg::DIR_UP;
          next_cnt = 8'(cnt + 8'h01);
        end else begin
          next_cnt = 8'(cnt - 8'h01);
        end
      end else begin
        next_dir = t8pwm_pkg::DIR_UP;
        next_cnt = 8'(cnt + 8'h01);
      end
    end
    if (wr_pend && wr_addr == t8pwm_pkg::ADDR_COUNT) begin
      next_cnt = hwdata[7:0];
    end
  end

  // Compare registers, outputs and flags
  always_comb begin
    next_bufa = bufa;
    next_bufb = bufb;
    next_ctrl = ctrl;
    next_flags = flags;
    if (wr_pend) begin
      unique case (wr_addr)
        t8pwm_pkg::ADDR_CTRL: next_ctrl = hwdata[t8pwm_pkg::CTRL_W-1:0];
        t8pwm_pkg::ADDR_CMPA: next_bufa = hwdata[7:0];
        t8pwm_pkg::ADDR_CMPB: next_bufb = hwdata[7:0];
        t8pwm_pkg::ADDR_STATUS:
          next_flags = flags & ~hwdata[t8pwm_pkg::ST_W-1:0];
        default: next_flags = flags;
      endcase
    end
    // Hardware set wins over a software clear
    next_flags[t8pwm_pkg::ST_OVF] = next_flags[t8pwm_pkg::ST_OVF] | ovf_set;
    next_flags[t8pwm_pkg::ST_MATCH_A] =
      next_flags[t8pwm_pkg::ST_MATCH_A] | match_a;
    next_flags[t8pwm_pkg::ST_MATCH_B] =
      next_flags[t8pwm_pkg::ST_MATCH_B] | match_b;
    // Non-PWM modes use the written value directly
    next_ocra = (!is_pwm || load) ? bufa : ocra;
    next_ocrb = (!is_pwm || load) ? bufb : ocrb;
    next_oca = oc_next(ctrl.waveform_mode_sel, ctrl.chan_a_output_mode,
                       oca, match_a, up_eff, wrap, turn,
                       bufa == new_top);
    next_ocb = oc_next(ctrl.waveform_mode_sel, ctrl.chan_b_output_mode,
                       ocb, match_b, up_eff, wrap, turn,
                       bufb == new_top);
  end

  // Bus slave
  always_comb begin
    next_wr_pend = hsel && htrans[1] && hready && hwrite &&
                   hsize == 3'h2;
    next_wr_addr = wr_pend ? wr_addr : 8'h00;
    if (hsel && htrans[1] && hready) begin
      next_wr_addr = {haddr[7:2], 2'h0};
    end
    next_hrdata = hrdata;
    if (hsel && htrans[1] && hready && !hwrite) begin
      unique case ({haddr[7:2], 2'h0})
        t8pwm_pkg::ADDR_CTRL: next_hrdata = {17'h00000, ctrl};
        t8pwm_pkg::ADDR_CMPA: next_hrdata = {24'h000000, bufa};
        t8pwm_pkg::ADDR_CMPB: next_hrdata = {24'h000000, bufb};
        t8pwm_pkg::ADDR_COUNT: next_hrdata = {24'h000000, cnt};
        t8pwm_pkg::ADDR_STATUS: next_hrdata = {29'h00000000, flags};
        default: next_hrdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= t8pwm_pkg::CTRL_RST;
      cnt <= t8pwm_pkg::CNT_BOTTOM;
      dir <= t8pwm_pkg::DIR_UP;
      ocra <= t8pwm_pkg::CMP_RST;
      ocrb <= t8pwm_pkg::CMP_RST;
      bufa <= t8pwm_pkg::CMP_RST;
      bufb <= t8pwm_pkg::CMP_RST;
      oca <= 1'b0;
      ocb <= 1'b0;
      flags <= t8pwm_pkg::ST_RST;
      presc <= t8pwm_pkg::PRESC_RST;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h00000000;
    end else begin
      ctrl <= next_ctrl;
      cnt <= next_cnt;
      dir <= next_dir;
      ocra <= next_ocra;
      ocrb <= next_ocrb;
      bufa <= next_bufa;
      bufb <= next_bufb;
      oca <= next_oca;
      ocb <= next_ocb;
      flags <= next_flags;
      presc <= next_presc;
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      hrdata <= next_hrdata;
    end
  end

  // Pin muxing
  always_comb begin
    hreadyout = 1'b1;
    hresp = 1'b0;
    chan_a_pin_out = (ctrl.chan_a_output_mode != t8pwm_pkg::COM_OFF) ?
                     oca : ctrl.pin_a_data;
    chan_b_pin_out = (ctrl.chan_b_output_mode != t8pwm_pkg::COM_OFF) ?
                     ocb : ctrl.pin_b_data;
    chan_a_pin_oe = ctrl.pin_a_dir;
    chan_b_pin_oe = ctrl.pin_b_dir;
    counter_value = cnt;
    overflow_flag = flags[t8pwm_pkg::ST_OVF];
    chan_a_match_flag = flags[t8pwm_pkg::ST_MATCH_A];
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_fast_count: assert property (is_fast && tick && !at_top && !wr_pend
    |=> cnt == 8'($past(cnt) + 8'h01)) else $error("fast count");
  a_var_top: assert property (
    ctrl.waveform_mode_sel == t8pwm_pkg::WAVE_FAST_VAR && tick &&
    cnt == ocra && !wr_pend |=> cnt == 8'h00)
    else $error("var top wrap");
  a_fast_wrap: assert property (wrap && !wr_pend |=> cnt == 8'h00)
    else $error("fast wrap");
  a_noninv_clear: assert property (is_fast && match_a && !wrap &&
    ctrl.chan_a_output_mode == t8pwm_pkg::COM_NONINV |=> !oca)
    else $error("noninv clear");
  a_fast_ovf: assert property (wrap |=> overflow_flag)
    else $error("fast ovf");
  a_pin_hidden: assert property (!ctrl.pin_a_dir |-> !chan_a_pin_oe)
    else $error("pin oe");
  a_buffer_hold: assert property (is_pwm && !load && !wr_pend
    |=> $stable(ocra)) else $error("buffer hold");
  a_pc_turn: assert property (turn && !wr_pend |=>
    dir == t8pwm_pkg::DIR_DOWN && cnt == 8'($past(cnt) - 8'h01))
    else $error("pc turn");
  a_pc_bottom: assert property (is_pc && tick &&
    dir == t8pwm_pkg::DIR_DOWN && cnt == 8'h00 && !wr_pend
    |=> dir == t8pwm_pkg::DIR_UP && cnt == 8'h01 && overflow_flag)
    else $error("pc bottom");
  a_com_off: assert property (
    ctrl.chan_a_output_mode == t8pwm_pkg::COM_OFF |=> $stable(oca))
    else $error("com off");
  a_override: assert property (
    ctrl.chan_a_output_mode != t8pwm_pkg::COM_OFF |->
    chan_a_pin_out == oca) else $error("override");

  c_fast_wrap: cover property (wrap ##1 match_a);
  c_pc_turn: cover property (turn ##[1:600] (is_pc && tick && cnt == 8'h00));
  c_oca_rise: cover property (is_pc && $rose(oca));
  c_async: cover property (ctrl.async_sel && tick);

endmodule // t8pwm_top

// ### t8pwm_load.sv
// External load on a compare output pin: a resistive pull-down.
// Assumes the pin is split into level and drive enable, enable high.
module t8pwm_load (
  // Pin as driven by the timer
  input wire logic pin_out,
  input wire logic pin_oe,
  // Level seen by the load
  output logic level
);
  timeunit 1ns;
  timeprecision 1ns;

  // Undriven pin falls to the pull-down level
  assign level = pin_oe ? pin_out : 1'b0;
endmodule // t8pwm_load

// ### timer8_pwm_waveform_modes_bench.sv
// Self-checking bench for the 8-bit PWM timer.
// Assumes t8pwm_top as the device and t8pwm_load on channel A.
module timer8_pwm_waveform_modes_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic hresp;
  logic [31:0] hrdata;
  logic osc_tick = 1'b0;
  logic [1:0] osc_div = 2'h0;
  logic a_out;
  logic a_oe;
  logic level_a;
  logic [7:0] counter_value;
  logic overflow_flag;
  logic chan_a_match_flag;
  int error_cnt = 0;
  int n_compared = 0;
  int cycles = 0;

  always #20 hclk = ~hclk;

  t8pwm_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
    .hrdata(hrdata), .osc_tick(osc_tick), .chan_a_pin_out(a_out),
    .chan_a_pin_oe(a_oe), .chan_b_pin_out(), .chan_b_pin_oe(),
    .counter_value(counter_value), .overflow_flag(overflow_flag),
    .chan_a_match_flag(chan_a_match_flag));

  t8pwm_load load_a (.pin_out(a_out), .pin_oe(a_oe), .level(level_a));

  // Oscillator stand-in: one tick every fourth cycle
  always @(posedge hclk) begin
    osc_div <= osc_div + 2'h1;
    osc_tick <= (osc_div == 2'h3);
  end

  task automatic results();
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      error_cnt++;
      results();
    end
  end

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic ahb_xfer(input logic wr, input logic [7:0] a,
                          input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb_xfer(1'b1, a, d, q);
  endtask

  // Reset values, read-back width and an unmapped place
  task automatic reg_reset();
    logic [31:0] q;
    for (int i = 0; i < 6; i++) begin
      ahb_xfer(1'b0, 8'(4 * i), 32'h0, q);
      check("reset read", q, 32'h0);
    end
    wr(8'h14, 32'hFFFFFFFF);
    ahb_xfer(1'b0, 8'h14, 32'h0, q);
    check("unmapped", q, 32'h0);
    wr(t8pwm_pkg::ADDR_CMPA, 32'hFFFFFFFF);
    ahb_xfer(1'b0, t8pwm_pkg::ADDR_CMPA, 32'h0, q);
    check("cmpa width", q, 32'h000000FF);
    check("hresp", {31'h0, hresp}, 32'h0);
    check("match flag reset", {31'h0, chan_a_match_flag}, 32'h0);
  endtask

  // Set a mode, let it settle, then count pin-high and bottom cycles
  task automatic run_mode(input logic [2:0] wm, input logic [1:0] com,
      input logic [2:0] cs, input logic as, input logic dir,
      input logic dat, input logic [7:0] cmp, input int win,
      input int hi, input int zr);
    t8pwm_pkg::t8pwm_ctrl_s c;
    int h;
    int z;
    c = t8pwm_pkg::CTRL_RST;
    c.waveform_mode_sel = t8pwm_pkg::t8pwm_wave_e'(wm);
    c.chan_a_output_mode = t8pwm_pkg::t8pwm_com_e'(com);
    c.clk_sel = t8pwm_pkg::t8pwm_clk_e'(cs);
    c.async_sel = as;
    c.pin_a_dir = dir;
    c.pin_a_data = dat;
    wr(t8pwm_pkg::ADDR_CMPA, {24'h0, cmp});
    wr(t8pwm_pkg::ADDR_CTRL, {17'h0, c});
    repeat (2 * win) @(posedge hclk);
    h = 0;
    z = 0;
    repeat (win) begin
      @(posedge hclk);
      h += (level_a === 1'b1);
      z += (counter_value === t8pwm_pkg::CNT_BOTTOM);
    end
    check("high cycles", h, hi);
    check("bottom cycles", z, zr);
  endtask

  // Flag cleared by write, set again as the counter comes round
  task automatic ovf_check(input logic [2:0] wm);
    int n;
    wr(t8pwm_pkg::ADDR_CTRL, {17'h0, 3'h1, 4'h0, wm});
    n = 0;
    while (counter_value !== 8'h80 && n < 600) begin
      @(posedge hclk);
      n++;
    end
    wr(t8pwm_pkg::ADDR_STATUS, 32'h7);
    // Clear lands at this edge; look once it has settled
    #1;
    check("flag cleared", {31'h0, overflow_flag}, 32'h0);
    n = 0;
    while (counter_value !== 8'h00 && n < 600) begin
      @(posedge hclk);
      n++;
    end
    @(posedge hclk);
    #1;
    check("flag set", {31'h0, overflow_flag}, 32'h1);
    // Active compare is 0x3F, so the count passes a match on its way up
    n = 0;
    while (counter_value !== 8'h40 && n < 600) begin
      @(posedge hclk);
      n++;
    end
    @(posedge hclk);
    #1;
    check("match flag set", {31'h0, chan_a_match_flag}, 32'h1);
  endtask

  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    reg_reset();
    // mode, output mode, clock, async, dir, data, compare, window, hi, bottom
    run_mode(3'h3, 2'h2, 3'h1, 0, 1, 0, 8'h40, 256, 65, 1);
    run_mode(3'h3, 2'h3, 3'h1, 0, 1, 0, 8'h40, 256, 191, 1);
    run_mode(3'h3, 2'h3, 3'h1, 0, 0, 0, 8'h40, 256, 0, 1);
    run_mode(3'h3, 2'h2, 3'h1, 0, 1, 0, 8'h00, 256, 1, 1);
    run_mode(3'h3, 2'h2, 3'h1, 0, 1, 0, 8'hFF, 256, 256, 1);
    run_mode(3'h7, 2'h1, 3'h1, 0, 1, 0, 8'h00, 256, 128, 256);
    run_mode(3'h7, 2'h0, 3'h1, 0, 1, 1, 8'h3F, 256, 256, 4);
    run_mode(3'h3, 2'h2, 3'h2, 0, 1, 0, 8'h40, 2048, 520, 8);
    run_mode(3'h3, 2'h2, 3'h1, 1, 1, 0, 8'h40, 1024, 260, 4);
    run_mode(3'h1, 2'h2, 3'h1, 0, 1, 0, 8'h40, 510, 128, 1);
    run_mode(3'h1, 2'h3, 3'h1, 0, 1, 0, 8'h40, 510, 382, 1);
    run_mode(3'h1, 2'h2, 3'h1, 0, 1, 0, 8'h00, 510, 0, 1);
    run_mode(3'h1, 2'h2, 3'h1, 0, 1, 0, 8'hFF, 510, 510, 1);
    run_mode(3'h5, 2'h0, 3'h1, 0, 1, 0, 8'h3F, 504, 0, 4);
    ovf_check(3'h3);
    ovf_check(3'h1);
    results();
  end
endmodule // timer8_pwm_waveform_modes_bench
